// File: design/rss_top.sv
// reset combiner, reset cause status register and clock pick at reset
// assumes cpu-side sources on clk; brown-out and clear pin are asynchronous
module rss_top
   import rss_pkg::*;
#(
   parameter int RST_CNT = rss_pkg::RST_CYCLES,
   parameter int POR_CNT = rss_pkg::POR_CYCLES
)
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              brownOutReset,
   input  wire logic              externalClearPin,
   input  wire rss_pkg::rss_src_s src,
   input  wire rss_pkg::rss_pwr_s pwr,
   input  wire rss_pkg::rss_cfg_s cfg,
   output logic                   masterSystemReset,
   output logic                   watchdogRun,
   output logic                   regulatorStandbyCtl,
   output rss_pkg::rss_sel_t      clkSel,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata
);
   import rss_pkg::*;

   localparam rss_cnt_t RST_LOAD = rss_cnt_t'(RST_CNT);
   localparam rss_cnt_t POR_LOAD = rss_cnt_t'(POR_CNT);
   localparam rss_cnt_t CNT_ONE  = rss_cnt_t'(1);

   typedef struct packed
   {
      rss_state_e  state;
      rss_cnt_t    cnt;
      logic [15:0] status;
      rss_sel_t    clkSel;
      logic        master_system_reset;
      logic        wdRun;
      logic        regStandby;
      logic        wrPend;
      logic [31:0] rdata;
   } rss_reg_s;

   // ==========================================================
   // reset release and pin synchronisers
   logic       rstSyncN;
   logic [1:0] pinSync;
   logic       brownSync;
   logic       extSync;

   rss_sync #(.WIDTH(1)) uRstSync
   (
      .clk  (clk),
      .rstN (rst_n),
      .d    (1'b1),
      .q    (rstSyncN)
   );

   rss_sync #(.WIDTH(2)) uPinSync
   (
      .clk  (clk),
      .rstN (rstSyncN),
      .d    ({brownOutReset, externalClearPin}),
      .q    (pinSync)
   );

   assign brownSync = pinSync[1];
   assign extSync = pinSync[0];

   // ==========================================================
   // state
   rss_reg_s s;
   rss_reg_s next_s;
   logic     anySrc;
   logic     addrPhase;
   logic     wrHit;
   logic     wdtClr;
   logic [15:0] setMask;
   rss_stateword_s stateWord;

   always_comb
   begin
      // brown-out counts as a source as well
      anySrc = brownSync | extSync | src.trapConflict | src.illegalAccess
             | src.softwareReset | src.watchdogReset;
      addrPhase = hsel & htrans[1] & hready;
      wrHit  = s.wrPend;
      wdtClr = pwr.sleepCmd | pwr.idleCmd;
      setMask = '0;
      setMask[BIT_TRAP]  = src.trapConflict;
      setMask[BIT_ILL]   = src.illegalAccess;
      setMask[BIT_EXT]   = extSync;
      setMask[BIT_SOFT]  = src.softwareReset;
      setMask[BIT_WDOG]  = src.watchdogReset;
      setMask[BIT_SLEEP] = pwr.sleepCmd;
      setMask[BIT_IDLE]  = pwr.idleCmd;
      setMask[BIT_BROWN] = brownSync;

      next_s = s;

      // software write lands in the data phase; bits are status only
      if (wrHit)
      begin
         next_s.status = hwdata[15:0] & STATUS_MASK;
      end
      if (wdtClr)
      begin
         next_s.status[BIT_WDOG] = 1'b0;
      end
      // hardware sets applied last so they win over the write
      next_s.status = (next_s.status | setMask) & STATUS_MASK;

      // sequencer: the register above is untouched by it
      case (s.state)
         ST_POR:
         begin
            next_s.clkSel = cfg.oscillatorConfigField;
            if (anySrc)
            begin
               next_s.cnt = POR_LOAD;
            end
            else if (s.cnt <= CNT_ONE)
            begin
               next_s.state = ST_RUN;
            end
            else
            begin
               next_s.cnt = s.cnt - CNT_ONE;
            end
         end
         ST_HOLD:
         begin
            if (anySrc)
            begin
               next_s.cnt = RST_LOAD;
            end
            else if (s.cnt <= CNT_ONE)
            begin
               next_s.state = ST_RUN;
            end
            else
            begin
               next_s.cnt = s.cnt - CNT_ONE;
            end
         end
         ST_RUN:
         begin
            if (brownSync)
            begin
               // brown-out takes the long delay and the fuse clock
               next_s.state  = ST_POR;
               next_s.cnt    = POR_LOAD;
               next_s.clkSel = cfg.oscillatorConfigField;
            end
            else if (anySrc)
            begin
               next_s.state = ST_HOLD;
               next_s.cnt   = RST_LOAD;
               next_s.clkSel = cfg.clkSwitchEnable
                             ? cfg.currentOscillatorBits
                             : cfg.oscillatorConfigField;
            end
         end
         default:
         begin
            next_s.state = ST_POR;
            next_s.cnt   = POR_LOAD;
         end
      endcase

      next_s.master_system_reset = anySrc | (next_s.state != ST_RUN);
      next_s.wdRun  = next_s.status[BIT_SWDT]
                    | cfg.watchdogFuseEnable;
      next_s.regStandby = next_s.status[BIT_VREG] & pwr.sleeping;

      // bus: zero wait, always okay; unmapped reads return zero
      next_s.wrPend = addrPhase & hwrite & (haddr == ADDR_STATUS);
      stateWord = '{zero: '0, clkSel: s.clkSel, watchdogRun: s.wdRun,
                    master_system_reset: s.master_system_reset, state: s.state};
      if (addrPhase & ~hwrite)
      begin
         if (haddr == ADDR_STATUS)
         begin
            next_s.rdata = {16'h0000, next_s.status};
         end
         else if (haddr == ADDR_STATE)
         begin
            next_s.rdata = stateWord;
         end
         else
         begin
            next_s.rdata = '0;
         end
      end
   end

   // only the power-on reset reloads the status register; other resets just set their own flag
   always_ff @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         s <= '{state: ST_POR, cnt: POR_LOAD, status: STATUS_POR,
                clkSel: '0, master_system_reset: 1'b1, wdRun: 1'b0,
                regStandby: 1'b0, wrPend: 1'b0, rdata: '0};
      end
      else
      begin
         s <= next_s;
      end
   end

   assign masterSystemReset   = s.master_system_reset;
   assign watchdogRun         = s.wdRun;
   assign regulatorStandbyCtl = s.regStandby;
   assign clkSel              = s.clkSel;
   assign hreadyout           = 1'b1;
   assign hresp               = 1'b0;
   assign hrdata              = s.rdata;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSyncN);

   sequence s_hold_done;
      (s.state == ST_HOLD) && (s.cnt == CNT_ONE) && !anySrc;
   endsequence

   sequence s_released;
      !masterSystemReset ##0 (s.state == ST_RUN);
   endsequence

   property p_src_reset;
      anySrc |=> masterSystemReset;
   endproperty
   a_src_reset: assert property (p_src_reset)
      else $error("source did not raise system reset");

   property p_release;
      s_hold_done |=> s_released;
   endproperty
   a_release: assert property (p_release)
      else $error("reset not released after hold");

   property p_no_early_release;
      $fell(masterSystemReset) |-> $past(s.cnt) == CNT_ONE;
   endproperty
   a_no_early_release: assert property (p_no_early_release)
      else $error("reset released before delay");

   property p_trap_flag;
      src.trapConflict |=> s.status[BIT_TRAP];
   endproperty
   a_trap_flag: assert property (p_trap_flag)
      else $error("trap flag not set");

   property p_ill_flag;
      src.illegalAccess |=> s.status[BIT_ILL];
   endproperty
   a_ill_flag: assert property (p_ill_flag)
      else $error("illegal access flag not set");

   property p_ext_flag;
      extSync |=> s.status[BIT_EXT];
   endproperty
   a_ext_flag: assert property (p_ext_flag)
      else $error("external pin flag not set");

   property p_soft_over_write;
      (src.softwareReset && wrHit && !hwdata[BIT_SOFT])
         |=> s.status[BIT_SOFT];
   endproperty
   a_soft_over_write: assert property (p_soft_over_write)
      else $error("software write beat hardware set");

   property p_wdog_clear;
      (wdtClr && !src.watchdogReset && !wrHit) |=> !s.status[BIT_WDOG];
   endproperty
   a_wdog_clear: assert property (p_wdog_clear)
      else $error("power-save did not clear watchdog flag");

   property p_unimpl;
      (s.status & UNIMPL_MASK) == '0;
   endproperty
   a_unimpl: assert property (p_unimpl)
      else $error("unimplemented status bits set");

   property p_clk_pick;
      (s.state == ST_RUN && anySrc && !brownSync)
         |=> clkSel == ($past(cfg.clkSwitchEnable)
                        ? $past(cfg.currentOscillatorBits)
                        : $past(cfg.oscillatorConfigField));
   endproperty
   a_clk_pick: assert property (p_clk_pick)
      else $error("wrong clock source picked at reset");

endmodule : rss_top

// File: common/rss_pkg.sv
// constants, types and register layout of the reset source status unit
// assumes one 50 MHz clock and an AHB-Lite master reaching the registers
//
// Overview of operation
// - any active reset source drives the master system reset.
// - each reset sets the status flag matching its cause.
// - power-on reset clears all set flags except the power-on and brown-out flags.
// - software may set or clear any flag; setting never causes a reset.
// - trap-conflict flag, bit 15, set by trap conflict, cleared by POR or software.
// - illegal-access flag, bit 14, set by illegal opcode, mode or pointer use.
// - external-pin flag, bit 7, set by the clear pin, cleared by POR.
// - software-reset flag, bit 6, set by reset instruction, cleared by POR.
// - watchdog flag, bit 4, set by time-out, cleared by power-save or POR.
// - sleep flag bit 3, idle flag bit 2, set by power-save, cleared by POR.
// - brown-out flag bit 1, power-on flag bit 0; both one after power-on.
// - bit 5 enables the watchdog; the fuse bit forces it on.
// - bit 8 puts the regulator in standby during sleep.
// - bits 13 to 9 are unimplemented and read zero.
// - switching on: power-on, brown-out use config field, others current bits.
// - switching off: every reset uses the oscillator config field.
// - undefined registers keep their values across non-power-on resets.
// - system reset held until power-on and start-up delays expire.

package rss_pkg;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int TPOR_NS       = 10000;
   localparam int TSTARTUP_NS   = 20000;
   localparam int TRST_NS       = 20000;
   localparam int RST_CYCLES    =
      (TRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_CYCLES    =
      (TPOR_NS + TSTARTUP_NS + TRST_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int CNT_W         = 12;
   localparam int SEL_W         = 3;

   typedef logic [CNT_W-1:0] rss_cnt_t;
   typedef logic [SEL_W-1:0] rss_sel_t;

   // ==========================================================
   // status register layout
   localparam int BIT_POR   = 0;
   localparam int BIT_BROWN = 1;
   localparam int BIT_IDLE  = 2;
   localparam int BIT_SLEEP = 3;
   localparam int BIT_WDOG  = 4;
   localparam int BIT_SWDT  = 5;
   localparam int BIT_SOFT  = 6;
   localparam int BIT_EXT   = 7;
   localparam int BIT_VREG  = 8;
   localparam int BIT_ILL   = 14;
   localparam int BIT_TRAP  = 15;
   localparam logic [15:0] STATUS_MASK  = 16'hc1ff;
   localparam logic [15:0] STATUS_POR   = 16'h0003;
   localparam logic [15:0] UNIMPL_MASK  = 16'h3e00;

   // ==========================================================
   // bus map
   localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATE  = 32'h0000_0004;
   localparam logic [1:0]  HTRANS_BUSY = 2'h1;

   // ==========================================================
   // types
   typedef enum logic [2:0]
   {
      ST_POR  = 3'h1,
      ST_HOLD = 3'h2,
      ST_RUN  = 3'h4
   } rss_state_e;

   typedef struct packed
   {
      logic trapConflict;
      logic illegalAccess;
      logic softwareReset;
      logic watchdogReset;
   } rss_src_s;

   typedef struct packed
   {
      logic sleepCmd;
      logic idleCmd;
      logic sleeping;
   } rss_pwr_s;

   typedef struct packed
   {
      logic     clkSwitchEnable;
      logic     watchdogFuseEnable;
      rss_sel_t oscillatorConfigField;
      rss_sel_t currentOscillatorBits;
   } rss_cfg_s;

   typedef struct packed
   {
      logic [23:0] zero;
      rss_sel_t    clkSel;
      logic        watchdogRun;
      logic        master_system_reset;
      rss_state_e  state;
   } rss_stateword_s;

endpackage : rss_pkg

// File: design/rss_sync.sv
// two-stage synchroniser for levels entering the clock domain
// assumes an asynchronous active-low reset; stage one feeds stage two only
module rss_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk,
   input  wire logic             rstN,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   // ==========================================================
   // stages
   logic [1:0][WIDTH-1:0] stages;
   logic [1:0][WIDTH-1:0] next_stages;

   always_comb
   begin
      next_stages[0] = d;
      next_stages[1] = stages[0];
   end

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         stages <= '0;
      end
      else
      begin
         stages <= next_stages;
      end
   end

   assign q = stages[1];

endmodule : rss_sync

// File: tb/rss_source_model.sv
// model of the reset sources and power-save instruction events
// assumes requests come from the bench just after a rising clk edge
module rss_source_model
   import rss_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        fire,
   input  wire logic [2:0]  kind,
   input  wire logic [3:0]  len,
   input  wire logic        sleeping,
   output logic             brownOutReset,
   output logic             externalClearPin,
   output rss_pkg::rss_src_s src,
   output rss_pkg::rss_pwr_s pwr
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // pulse generator
   // pins need several cycles, they cross a two-flop synchroniser
   logic [3:0] left = 4'h0;
   logic [2:0] sel  = 3'h0;
   logic       act;

   always_ff @(posedge clk)
   begin
      if (fire)
      begin
         left <= len;
         sel  <= kind;
      end
      else if (left != 4'h0)
         left <= left - 4'h1;
   end

   always_comb
   begin
      act               = (left != 4'h0);
      brownOutReset     = act && (sel == 3'h0);
      externalClearPin  = act && (sel == 3'h1);
      src.trapConflict  = act && (sel == 3'h2);
      src.illegalAccess = act && (sel == 3'h3);
      src.softwareReset = act && (sel == 3'h4);
      src.watchdogReset = act && (sel == 3'h5);
      pwr.sleepCmd      = act && (sel == 3'h6);
      pwr.idleCmd       = act && (sel == 3'h7);
      pwr.sleeping      = sleeping;
   end
endmodule : rss_source_model

// File: tb/reset_source_status_unit_tb_top.sv
// self-checking bench of the reset source status unit
// assumes rss_top with short reset counts and the source model beside it
module reset_source_status_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import rss_pkg::*;

   // ==========================================================
   // signals
   localparam int RC = 8;
   localparam int PC = 20;
   logic        clk, rst_n, fire, sleeping, masterSystemReset;
   logic        hsel, hwrite, hreadyout, hresp, watchdogRun;
   logic        regulatorStandbyCtl, brownOutReset, externalClearPin;
   logic [2:0]  kind, hsize;
   logic [3:0]  len;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata;
   rss_sel_t    clkSel;
   rss_src_s    src;
   rss_pwr_s    pwr;
   rss_cfg_s    cfg;
   int          miscompares = 0;
   int          nChecks     = 0;
   int          cycles      = 0;

   rss_top #(.RST_CNT(RC), .POR_CNT(PC)) rss_top_inst (
      .clk(clk), .rst_n(rst_n), .brownOutReset(brownOutReset),
      .externalClearPin(externalClearPin), .src(src), .pwr(pwr),
      .cfg(cfg), .masterSystemReset(masterSystemReset),
      .watchdogRun(watchdogRun), .regulatorStandbyCtl(regulatorStandbyCtl),
      .clkSel(clkSel), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

   rss_source_model rss_source_model_inst (
      .clk(clk), .fire(fire), .kind(kind), .len(len),
      .sleeping(sleeping), .brownOutReset(brownOutReset),
      .externalClearPin(externalClearPin), .src(src), .pwr(pwr));

   // ==========================================================
   // clock, timeout, checks
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         stop_test();
      end
   end

   task automatic check_word(input string n, input logic [31:0] e, g);
      nChecks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : check_word

   task automatic check_bit(input string n, input logic e, g);
      check_word(n, {31'h0, e}, {31'h0, g});
   endtask : check_bit

   // single word transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
      check_bit("hresp", 1'b0, hresp);
   endtask : bus

   task automatic wait_rst(input logic v, input int lim);
      for (int i = 0; i < lim && masterSystemReset !== v; i++)
         @(posedge clk);
      check_bit("sysReset", v, masterSystemReset);
   endtask : wait_rst

   task automatic pulse(input logic [2:0] k, input logic [3:0] n);
      fire <= 1'b1;
      kind <= k;
      len  <= n;
      @(posedge clk);
      fire <= 1'b0;
   endtask : pulse

   // ==========================================================
   // scenarios
   task automatic test_por;
      logic [31:0] rd;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check_bit("hold", 1'b1, masterSystemReset);
      wait_rst(1'b0, PC + 8);
      bus(1'b0, ADDR_STATUS, '0, rd);
      check_word("status", 32'h0000_0003, rd);
      check_word("clkSel", {29'h0, cfg.oscillatorConfigField}, {29'h0, clkSel});
      // state word: run state, reset low, watchdog off, clock pick
      bus(1'b0, ADDR_STATE, '0, rd);
      check_word("state", {24'h0, cfg.oscillatorConfigField, 2'b00, ST_RUN},
                 rd);
      $display("test_por done");
   endtask : test_por

   task automatic test_sw;
      logic [31:0] rd;
      bus(1'b1, ADDR_STATUS, 32'h0000_ffff, rd);
      bus(1'b1, 32'h0000_0010, 32'hffff_ffff, rd);
      bus(1'b0, 32'h0000_0010, '0, rd);
      check_word("unmapped", 32'h0, rd);
      bus(1'b0, ADDR_STATUS, '0, rd);
      check_word("rw", 32'h0000_c1ff, rd);
      check_bit("sysReset", 1'b0, masterSystemReset);
      check_bit("wdt", 1'b1, watchdogRun);
      sleeping <= 1'b1;
      repeat (2) @(posedge clk);
      check_bit("vreg", 1'b1, regulatorStandbyCtl);
      bus(1'b1, ADDR_STATUS, 32'h0, rd);
      cfg.watchdogFuseEnable <= 1'b1;
      repeat (2) @(posedge clk);
      check_bit("vreg", 1'b0, regulatorStandbyCtl);
      check_bit("wdt", 1'b1, watchdogRun);
      cfg.watchdogFuseEnable <= 1'b0;
      sleeping <= 1'b0;
      repeat (2) @(posedge clk);
      check_bit("wdt", 1'b0, watchdogRun);
      $display("test_sw done");
   endtask : test_sw

   task automatic test_src;
      logic [31:0] rd;
      logic [2:0]  es;
      logic [15:0] eb [6] = '{16'h0002, 16'h0080, 16'h8000, 16'h4000,
                              16'h0040, 16'h0010};
      cfg.clkSwitchEnable <= 1'b1;
      for (int k = 0; k < 6; k++)
      begin
         // vreg bit stays set: non power-on resets keep the register
         bus(1'b1, ADDR_STATUS, 32'h0000_0100, rd);
         pulse(3'(k), (k < 2) ? 4'h3 : 4'h1);
         wait_rst(1'b1, 8);
         wait_rst(1'b0, PC + 16);
         bus(1'b0, ADDR_STATUS, '0, rd);
         check_word("cause", {16'h0, 16'h0100 | eb[k]}, rd);
         es = (k == 0) ? cfg.oscillatorConfigField : cfg.currentOscillatorBits;
         check_word("clkSel", {29'h0, es}, {29'h0, clkSel});
      end
      $display("test_src done");
   endtask : test_src

   task automatic test_pwr;
      logic [31:0] rd;
      bus(1'b1, ADDR_STATUS, 32'h0000_0010, rd);
      pulse(3'h6, 4'h1);
      repeat (3) @(posedge clk);
      bus(1'b0, ADDR_STATUS, '0, rd);
      check_word("sleep", 32'h0000_0008, rd);
      pulse(3'h7, 4'h1);
      repeat (3) @(posedge clk);
      bus(1'b0, ADDR_STATUS, '0, rd);
      check_word("idle", 32'h0000_000c, rd);
      // software reset lands in the same cycle as a clearing write
      fork
         pulse(3'h4, 4'h1);
         bus(1'b1, ADDR_STATUS, 32'h0, rd);
      join
      wait_rst(1'b1, 4);
      wait_rst(1'b0, RC + 8);
      bus(1'b0, ADDR_STATUS, '0, rd);
      check_word("hwWins", 32'h0000_0040, rd);
      bus(1'b1, ADDR_STATUS, 32'h0000_c1fc, rd);
      cfg.clkSwitchEnable <= 1'b0;
      $display("test_pwr done");
   endtask : test_pwr

   task automatic stop_test;
      $display("checks %0d miscompares %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   // ==========================================================
   // main sequence
   initial
   begin
      rst_n    = 1'b0;
      fire     = 1'b0;
      kind     = 3'h0;
      len      = 4'h0;
      sleeping = 1'b0;
      cfg      = '{1'b0, 1'b0, 3'h5, 3'h2};
      hsel     = 1'b0;
      haddr    = 32'h0;
      htrans   = 2'h0;
      hwrite   = 1'b0;
      hsize    = 3'h2;
      hwdata   = 32'h0;
      @(posedge clk);
      test_por();
      test_sw();
      test_src();
      test_pwr();
      // second power-on with flags set and switching off
      test_por();
      stop_test();
   end
endmodule : reset_source_status_unit_tb_top
